/* verilog/abu_pkg.sv */
// Shared constants and types of the address breakpoint unit
package abu_pkg;

	// Bus geometry
	localparam int ABU_PADDR_W = 8;
	localparam int ABU_PDATA_W = 32;
	localparam int ABU_CPU_AW  = 16;

	// Register byte addresses, one aligned word each
	localparam logic [7:0] ABU_OFS_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] ABU_OFS_ADDR_HIGH      = 8'h04;
	localparam logic [7:0] ABU_OFS_ADDR_LOW       = 8'h08;
	localparam logic [7:0] ABU_OFS_WAKE_STATUS    = 8'h0C;
	localparam logic [7:0] ABU_OFS_FLAG_CLEAR     = 8'h10;
	localparam logic [7:0] ABU_OFS_IRQ_STATUS     = 8'h14;
	localparam logic [7:0] ABU_OFS_IRQ_MASK       = 8'h18;

	// Field positions
	localparam int ABU_BIT_BREAK_ENABLE = 7;
	localparam int ABU_BIT_BREAK_ACTIVE = 6;
	localparam int ABU_BIT_STOP_WAIT    = 1;
	localparam int ABU_BIT_CLEAR_ENABLE = 7;
	localparam int ABU_IRQ_BIT_TAKEN    = 0;
	localparam int ABU_IRQ_BIT_WAKE     = 1;
	localparam int ABU_IRQ_W            = 2;

	// Reset values
	localparam logic [7:0] ABU_RST_BYTE = 8'h00;
	localparam logic       ABU_RST_BIT  = 1'b0;
	localparam logic [31:0] ABU_RST_WORD = 32'h0000_0000;
	localparam logic [1:0] ABU_RST_IRQ  = 2'h0;

	// Break request sequencer, one-hot
	typedef enum logic [1:0] {
		ABU_IDLE = 2'b01,
		ABU_PEND = 2'b10
	} abu_state_type;

endpackage

/* verilog/abu_match.sv */
// Address comparator of the address breakpoint unit
`timescale 1ns/1ps
module abu_match (
	// Compared values
	input  wire logic [abu_pkg::ABU_CPU_AW-1:0] cpu_addr,
	input  wire logic [7:0]                     addr_high,
	input  wire logic [7:0]                     addr_low,
	input  wire logic                           enable,
	// Result
	output logic                                hit
);
	import abu_pkg::*;

	// Comparison does not depend on wait mode, so it keeps working there
	always_comb begin
		hit = enable && (cpu_addr == {addr_high, addr_low});
	end

endmodule

/* verilog/abu_irq.sv */
// Sticky event flags, mask and interrupt line of the breakpoint unit
`timescale 1ns/1ps
module abu_irq #(
	parameter int N = abu_pkg::ABU_IRQ_W
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Events and software access
	input  wire logic [N-1:0] event_set,
	input  wire logic         status_wr,
	input  wire logic         mask_wr,
	input  wire logic [N-1:0] wdata,
	// State and interrupt
	output logic      [N-1:0] status,
	output logic      [N-1:0] mask,
	output logic              irq
);
	import abu_pkg::*;

	typedef struct packed {
		logic [N-1:0] status;
		logic [N-1:0] mask;
	} abu_irq_state_type;

	abu_irq_state_type st_r;
	abu_irq_state_type st_nxt;

	always_comb begin
		st_nxt = st_r;
		// Write one clears; an event in the same cycle still wins
		if (status_wr) begin
			st_nxt.status = st_r.status & ~wdata;
		end
		st_nxt.status = st_nxt.status | event_set;
		if (mask_wr) begin
			st_nxt.mask = wdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign status = st_r.status;
	assign mask   = st_r.mask;
	assign irq    = |(st_r.status & st_r.mask);

endmodule

/* verilog/abu_top.sv */
// Address breakpoint unit: registers, break sequencing and wake logic
`timescale 1ns/1ps
module abu_top (
	// Clock and reset
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	// APB slave
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [abu_pkg::ABU_PADDR_W-1:0] paddr,
	input  wire logic [abu_pkg::ABU_PDATA_W-1:0] pwdata,
	output logic                                 pready,
	output logic      [abu_pkg::ABU_PDATA_W-1:0] prdata,
	output logic                                 pslverr,
	// Processor side, same clock
	input  wire logic [abu_pkg::ABU_CPU_AW-1:0]  cpu_addr,
	input  wire logic                            instr_last_cycle,
	input  wire logic                            cpu_in_wait,
	input  wire logic                            cpu_in_stop,
	// System integration unit side
	output logic                                 breakpoint_request,
	output logic                                 break_start,
	output logic                                 stop_wake_request,
	output logic                                 break_state,
	output logic                                 status_clear_allowed,
	// Interrupt
	output logic                                 irq
);
	import abu_pkg::*;

	typedef struct packed {
		abu_state_type     state;
		logic              brk_enable;
		logic              brk_active;
		logic [7:0]        addr_high;
		logic [7:0]        addr_low;
		logic              stop_wait_exit;
		logic              clear_enable;
		logic [31:0]       rdata;
		logic              slverr;
	} abu_top_state_type;

	abu_top_state_type st_r;
	abu_top_state_type st_nxt;

	logic              hit;
	logic              setup;
	logic              wr;
	logic              mapped;
	logic              wr_scr;
	logic              wr_hi;
	logic              wr_lo;
	logic              wr_bsr;
	logic              wr_break_flag_clear_control;
	logic              wr_ist;
	logic              wr_imsk;
	logic              sw_force;
	logic              req;
	logic              low_power;
	logic              take;
	logic              wake;
	logic [ABU_IRQ_W-1:0] irq_events;
	logic [ABU_IRQ_W-1:0] irq_status;
	logic [ABU_IRQ_W-1:0] irq_mask;
	logic [31:0]       rd_word;

	abu_match u_match (
		.cpu_addr  (cpu_addr),
		.addr_high (st_r.addr_high),
		.addr_low  (st_r.addr_low),
		.enable    (st_r.brk_enable),
		.hit       (hit)
	);

	// Bus decode
	assign setup   = psel && !penable;
	assign wr      = psel && penable && pwrite;
	assign wr_scr  = wr && (paddr == ABU_OFS_STATUS_CONTROL);
	assign wr_hi   = wr && (paddr == ABU_OFS_ADDR_HIGH);
	assign wr_lo   = wr && (paddr == ABU_OFS_ADDR_LOW);
	assign wr_bsr  = wr && (paddr == ABU_OFS_WAKE_STATUS);
	assign wr_break_flag_clear_control = wr && (paddr == ABU_OFS_FLAG_CLEAR);
	assign wr_ist  = wr && (paddr == ABU_OFS_IRQ_STATUS);
	assign wr_imsk = wr && (paddr == ABU_OFS_IRQ_MASK);

	// Software trigger needs no address match
	assign sw_force = wr_scr && pwdata[ABU_BIT_BREAK_ACTIVE];

	// Request stays up from the event until the break is taken
	assign req = hit || sw_force || (st_r.state == ABU_PEND);

	// In stop or wait no instruction completes, so a request is taken
	// at once and doubles as the wake-up
	assign low_power = cpu_in_stop || cpu_in_wait;
	assign wake      = req && low_power;

	// A match on the last cycle is taken in the same cycle
	assign take = req && (instr_last_cycle || low_power);

	assign irq_events[ABU_IRQ_BIT_TAKEN] = take;
	assign irq_events[ABU_IRQ_BIT_WAKE]  = wake;

	abu_irq #(
		.N (ABU_IRQ_W)
	) u_irq (
		.pclk      (pclk),
		.presetn   (presetn),
		.event_set (irq_events),
		.status_wr (wr_ist),
		.mask_wr   (wr_imsk),
		.wdata     (pwdata[ABU_IRQ_W-1:0]),
		.status    (irq_status),
		.mask      (irq_mask),
		.irq       (irq)
	);

	// Read mux and address map
	always_comb begin
		rd_word = ABU_RST_WORD;
		mapped  = 1'b1;
		if (paddr == ABU_OFS_STATUS_CONTROL) begin
			rd_word[ABU_BIT_BREAK_ENABLE] = st_r.brk_enable;
			rd_word[ABU_BIT_BREAK_ACTIVE] = st_r.brk_active;
		end else if (paddr == ABU_OFS_ADDR_HIGH) begin
			rd_word[7:0] = st_r.addr_high;
		end else if (paddr == ABU_OFS_ADDR_LOW) begin
			rd_word[7:0] = st_r.addr_low;
		end else if (paddr == ABU_OFS_WAKE_STATUS) begin
			rd_word[ABU_BIT_STOP_WAIT] = st_r.stop_wait_exit;
		end else if (paddr == ABU_OFS_FLAG_CLEAR) begin
			rd_word[ABU_BIT_CLEAR_ENABLE] = st_r.clear_enable;
		end else if (paddr == ABU_OFS_IRQ_STATUS) begin
			rd_word[ABU_IRQ_W-1:0] = irq_status;
		end else if (paddr == ABU_OFS_IRQ_MASK) begin
			rd_word[ABU_IRQ_W-1:0] = irq_mask;
		end else begin
			mapped = 1'b0;
		end
	end

	always_comb begin
		st_nxt = st_r;

		// Read data and error are latched in the setup phase so that
		// the access phase completes with zero wait states
		if (setup) begin
			st_nxt.rdata  = pwrite ? ABU_RST_WORD : rd_word;
			st_nxt.slverr = !mapped;
		end

		if (wr_scr) begin
			st_nxt.brk_enable = pwdata[ABU_BIT_BREAK_ENABLE];
		end

		// Zero write clears active, but a new event in the same cycle wins
		if (wr_scr && !pwdata[ABU_BIT_BREAK_ACTIVE]) begin
			st_nxt.brk_active = 1'b0;
		end
		if (hit || sw_force) begin
			st_nxt.brk_active = 1'b1;
		end

		if (wr_hi) begin
			st_nxt.addr_high = pwdata[7:0];
		end
		if (wr_lo) begin
			st_nxt.addr_low = pwdata[7:0];
		end

		if (wr_bsr && !pwdata[ABU_BIT_STOP_WAIT]) begin
			st_nxt.stop_wait_exit = 1'b0;
		end
		if (wake) begin
			st_nxt.stop_wait_exit = 1'b1;
		end

		if (wr_break_flag_clear_control) begin
			st_nxt.clear_enable = pwdata[ABU_BIT_CLEAR_ENABLE];
		end

		case (st_r.state)
			ABU_IDLE: begin
				if (req && !take) begin
					st_nxt.state = ABU_PEND;
				end
			end
			ABU_PEND: begin
				if (take) begin
					st_nxt.state = ABU_IDLE;
				end
			end
			default: begin
				st_nxt.state = ABU_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r.state          <= ABU_IDLE;
			st_r.brk_enable     <= ABU_RST_BIT;
			st_r.brk_active     <= ABU_RST_BIT;
			st_r.addr_high      <= ABU_RST_BYTE;
			st_r.addr_low       <= ABU_RST_BYTE;
			st_r.stop_wait_exit <= ABU_RST_BIT;
			st_r.clear_enable   <= ABU_RST_BIT;
			st_r.rdata          <= ABU_RST_WORD;
			st_r.slverr         <= ABU_RST_BIT;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs
	assign pready             = 1'b1;
	assign prdata             = st_r.rdata;
	assign pslverr            = st_r.slverr && psel && penable;
	assign breakpoint_request = req;
	assign break_start        = take;
	assign stop_wake_request  = wake;
	assign break_state        = st_r.brk_active;

	// Outside the break any flag may be cleared; inside it only if enabled
	assign status_clear_allowed = !st_r.brk_active || st_r.clear_enable;

endmodule

/* bench/abu_top_assertions.sv */
// Port-level assertions of the address breakpoint unit
`timescale 1ns/1ps
module abu_top_assertions (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Register bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	// Processor and integration side
	input wire logic        instr_last_cycle,
	input wire logic        cpu_in_wait,
	input wire logic        cpu_in_stop,
	input wire logic        breakpoint_request,
	input wire logic        break_start,
	input wire logic        stop_wake_request,
	input wire logic        break_state,
	input wire logic        status_clear_allowed
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_pend;
		breakpoint_request && !break_start;
	endsequence
	// Clearing write that carries no force of its own
	sequence s_clr;
		psel && penable && pwrite && paddr == 8'h00 && pwdata[7:6] == 2'h0;
	endsequence
	a_start_cause: assert property (break_start |-> breakpoint_request)
		else $error("break start without request");
	a_last_start: assert property (
		breakpoint_request && instr_last_cycle |-> break_start)
		else $error("match on last cycle did not start break");
	a_pend_hold: assert property (s_pend |=> breakpoint_request)
		else $error("pending request dropped early");
	// A pending request may outlive a clearing write, so only a fresh
	// request (match or force) is bound to set the active bit
	a_req_active: assert property ($rose(breakpoint_request) |=> break_state)
		else $error("request did not set active");
	a_clr_active: assert property (
		s_clr ##0 !breakpoint_request |=> !break_state)
		else $error("zero write left active set");
	a_stop_wake: assert property (
		breakpoint_request && cpu_in_stop |-> stop_wake_request && break_start)
		else $error("break in stop did not wake");
	a_wait_wake: assert property (
		breakpoint_request && cpu_in_wait |-> stop_wake_request)
		else $error("break in wait did not wake");
	a_clear_gate: assert property (!break_state |-> status_clear_allowed)
		else $error("flag clearing blocked outside break");
	a_active_keep: assert property (break_state && !psel |=> break_state)
		else $error("active lost without write");
endmodule

bind abu_top abu_top_assertions abu_top_assertions_inst (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .instr_last_cycle,
	.cpu_in_wait, .cpu_in_stop, .breakpoint_request, .break_start,
	.stop_wake_request, .break_state, .status_clear_allowed);

/* bench/abu_cpu_model.sv */
// Processor pacing model: marks the last cycle of each instruction
`timescale 1ns/1ps
module abu_cpu_model (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Pace select
	input  wire logic slow,
	// Instruction boundary
	output logic      instr_last_cycle
);
	logic [1:0] cnt_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_r <= 2'h0;
		else
			cnt_r <= cnt_r + 2'h1;
	end
	// Slow pace makes a pending request wait for a boundary
	assign instr_last_cycle = slow ? (cnt_r == 2'h3) : cnt_r[0];
endmodule

/* bench/tb_top.sv */
// Self-checking bench of the address breakpoint unit
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected at %0t got %h exp %h", $time, g, e); end end
module tb_top;
	import abu_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, slow;
	logic        cpu_in_wait, cpu_in_stop, instr_last_cycle;
	logic        pready, pslverr, irq, breakpoint_request, break_start;
	logic        stop_wake_request, break_state, status_clear_allowed;
	logic [7:0]  paddr;
	logic [15:0] cpu_addr, bp;
	logic [31:0] pwdata, prdata;
	logic [32:0] mon_e;
	logic [32:0] exp_q[$];
	int          bad_count, checks_done, tnum, starts, n0;

	abu_top abu_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .cpu_addr, .instr_last_cycle,
		.cpu_in_wait, .cpu_in_stop, .breakpoint_request, .break_start,
		.stop_wake_request, .break_state, .status_clear_allowed, .irq);
	abu_cpu_model abu_cpu_model_inst (.pclk, .presetn, .slow,
		.instr_last_cycle);

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask
	// A start may fall in the very cycle of the trigger, so starts are
	// counted at every rising edge and the task waits for the count to move
	task wait_start(input int base);
		repeat (8)
			if (starts == base)
				@(negedge pclk);
		`CHK(starts, base + 1)
	endtask
	task tend;
		$display("test %0d done", tnum);
		tnum++;
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	always @(posedge pclk) begin
		if (break_start === 1'b1)
			starts++;
	end

	// Read results are compared in the access phase, oldest note first
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			mon_e = exp_q.pop_front();
			`CHK({pslverr, prdata}, mon_e)
		end
	end

	initial begin
		repeat (5000) @(posedge pclk);
		bad_count++;
		end_sim;
	end

	initial begin
		{psel, penable, pwrite, cpu_in_wait, cpu_in_stop} = 5'h0;
		{paddr, pwdata, cpu_addr} = 56'h0;
		{slow, presetn} = 2'h2;
		{bad_count, checks_done, tnum} = 96'h0;
		void'($urandom(32'hF0CD9CEE));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++)
			rd(8'(4 * i), 33'h0);
		rd(8'h1C, 33'h1_0000_0000);
		tend;
		bp = 16'($urandom());
		wr(ABU_OFS_ADDR_HIGH, bp[15:8]);
		wr(ABU_OFS_ADDR_LOW, bp[7:0]);
		rd(ABU_OFS_ADDR_HIGH, {25'h0, bp[15:8]});
		rd(ABU_OFS_ADDR_LOW, {25'h0, bp[7:0]});
		cpu_addr <= bp;
		@(negedge pclk);
		`CHK(breakpoint_request, 1'b0)
		@(posedge pclk);
		cpu_addr <= ~bp;
		rd(ABU_OFS_STATUS_CONTROL, 33'h0);
		tend;
		wr(ABU_OFS_STATUS_CONTROL, 8'h80);
		n0 = starts;
		cpu_addr <= bp;
		@(negedge pclk);
		`CHK(breakpoint_request, 1'b1)
		@(posedge pclk);
		cpu_addr <= ~bp;
		wait_start(n0);
		rd(ABU_OFS_STATUS_CONTROL, 33'hC0);
		rd(ABU_OFS_IRQ_STATUS, 33'h1);
		@(negedge pclk);
		`CHK({irq, status_clear_allowed}, 2'h0)
		wr(ABU_OFS_IRQ_MASK, 8'h03);
		wr(ABU_OFS_FLAG_CLEAR, 8'h80);
		@(negedge pclk);
		`CHK({irq, status_clear_allowed}, 2'h3)
		wr(ABU_OFS_IRQ_STATUS, 8'h01);
		@(negedge pclk);
		`CHK(irq, 1'b0)
		wr(ABU_OFS_STATUS_CONTROL, 8'h80);
		rd(ABU_OFS_STATUS_CONTROL, 33'h80);
		wr(ABU_OFS_STATUS_CONTROL, 8'h00);
		rd(ABU_OFS_STATUS_CONTROL, 33'h0);
		tend;
		slow <= 1'b0;
		n0 = starts;
		wr(ABU_OFS_STATUS_CONTROL, 8'h40);
		wait_start(n0);
		rd(ABU_OFS_STATUS_CONTROL, 33'h40);
		wr(ABU_OFS_STATUS_CONTROL, 8'h80);
		tend;
		for (int m = 0; m < 2; m++) begin
			cpu_in_stop <= (m == 0);
			cpu_in_wait <= (m == 1);
			cpu_addr <= bp;
			@(negedge pclk);
			`CHK({stop_wake_request, break_start}, 2'h3)
			@(posedge pclk);
			{cpu_in_stop, cpu_in_wait} <= 2'h0;
			cpu_addr <= ~bp;
			rd(ABU_OFS_WAKE_STATUS, 33'h2);
			wr(ABU_OFS_WAKE_STATUS, 8'h00);
			rd(ABU_OFS_WAKE_STATUS, 33'h0);
		end
		tend;
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		rd(ABU_OFS_STATUS_CONTROL, 33'h0);
		rd(ABU_OFS_ADDR_HIGH, 33'h0);
		tend;
		end_sim;
	end
endmodule
